//--- logic/bus_controller_pkg.sv
// Package of constants for the system bus controller.
package bus_controller_pkg;
	localparam int addr_width = 32;
	localparam int data_width = 32;
	localparam int region_msb = 31;
	localparam int region_lsb = 28;
	localparam int area_msb = 27;
	localparam int area_lsb = 20;
	localparam logic [3:0] region_internal = 4'h0;
	localparam logic [3:0] region_peripheral = 4'hf;
	localparam logic [7:0] area_zero = 8'h00;
	localparam logic [7:0] area_flash = 8'h01;
	localparam logic [7:0] area_sram = 8'h02;
	localparam logic [7:0] area_rom = 8'h03;
	// Memory sizes as address widths inside a 1-Mbyte window; aliasing follows from them.
	localparam int flash_addr_bits = 18;
	localparam int sram_addr_bits = 17;
	localparam int rom_addr_bits = 14;
	// Transfer size encodings.
	localparam logic [1:0] size_byte = 2'h0;
	localparam logic [1:0] size_half = 2'h1;
	localparam logic [1:0] size_word = 2'h2;
	// Transfer type encodings.
	localparam logic [1:0] type_read = 2'h0;
	localparam logic [1:0] type_write = 2'h1;
	localparam logic [1:0] type_fetch = 2'h2;
	// Register byte offsets.
	localparam logic [3:0] remap_command_offset = 4'h0;
	localparam logic [3:0] abort_attribute_offset = 4'h4;
	localparam logic [3:0] abort_address_offset = 4'h8;
	// Field positions of the abort attribute register.
	localparam int undefined_bit = 0;
	localparam int misaligned_bit = 1;
	localparam int size_lsb = 8;
	localparam int type_lsb = 10;
	localparam int last_source_lsb = 16;
	localparam int saved_lsb = 24;
	localparam int remap_toggle_bit = 0;
	// Master indices, also bit order of the source fields.
	localparam int master_count = 3;
	localparam int master_ethernet = 0;
	localparam int master_dma = 1;
	localparam int master_cpu = 2;
	// Target select codes.
	localparam logic [2:0] target_none = 3'h0;
	localparam logic [2:0] target_flash = 3'h1;
	localparam logic [2:0] target_sram = 3'h2;
	localparam logic [2:0] target_rom = 3'h3;
	localparam logic [2:0] target_peripheral = 3'h4;
	localparam logic [1:0] axi_okay = 2'h0;
	localparam logic [1:0] axi_slverr = 2'h2;
	typedef enum logic [1:0] {
		arb_idle = 2'b00,
		arb_busy = 2'b01
	} arb_state_type;
endpackage : bus_controller_pkg

//--- logic/system_bus_controller.sv
// System bus controller: arbiter, decoder, remap, misalignment check and abort status.
//
// Overview of operation
// - Little-endian transfers only, all masters.
// - Fixed priority: ethernet, then DMA, then CPU.
// - Top four address bits select 256-Mbyte regions.
// - Undefined regions answer with abort.
// - Eight more bits pick 1-Mbyte memory windows.
// - Memories alias across their whole window.
// - Unallocated internal address returns abort.
// - Area 0 is flash, SRAM after remap.
// - Mapped memory also stays at normal location.
// - Writing one toggles remap; zero does nothing.
// - Abort indication goes to all masters.
// - Capture full 32-bit abort address.
// - Record transfer size of aborted access.
// - Record read, write or fetch type.
// - Set undefined or misaligned cause flag.
// - Exactly one last-source flag per abort.
// - Per-master saved flag since last status read.
// - CPU data abort captures the data address.
// - Misaligned word or half access aborts.
// - CPU instruction fetches skip alignment check.
// - Size code: byte, half, word, reserved.
// - Type code: read, write, fetch, reserved.
module system_bus_controller (
	// Clock and reset
	input wire logic core_clk,
	input wire logic reset,
	// Master requests, index 0 ethernet, 1 DMA, 2 CPU; little-endian data only
	input wire logic [2:0] master_req,
	input wire logic [31:0] master_addr [3],
	input wire logic [1:0] master_size [3],
	input wire logic [1:0] master_type [3],
	input wire logic [31:0] master_wdata [3],
	// Master answers
	output logic [2:0] master_grant,
	output logic master_done,
	output logic master_abort,
	output logic [31:0] master_rdata,
	// Memory side: one shared strobe with a target select
	output logic mem_valid,
	output logic [2:0] mem_target,
	output logic [31:0] mem_addr,
	output logic [1:0] mem_size,
	output logic mem_write,
	output logic [31:0] mem_wdata,
	input wire logic mem_ready,
	input wire logic [31:0] mem_rdata,
	// Remap state for observation
	output logic remap_active,
	// AXI4-Lite register slave
	input wire logic [31:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [31:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready
);
	bus_controller_pkg::arb_state_type state_reg;
	bus_controller_pkg::arb_state_type state_next;
	logic [2:0] grant_next;
	logic [1:0] owner_reg;
	logic [1:0] winner;
	logic any_req;
	logic remap_reg;
	// Abort status registers.
	logic [31:0] abort_address_reg;
	logic [1:0] abort_size_field;
	logic [1:0] abort_type_field;
	logic undefined_address_flag;
	logic misaligned_address_flag;
	logic [2:0] last_source_reg;
	logic [2:0] saved_reg;
	logic source_unread_reg;
	// Selected master request.
	logic [31:0] sel_addr;
	logic [1:0] sel_size;
	logic [1:0] sel_type;
	logic [31:0] sel_wdata;
	logic [3:0] sel_region;
	logic [7:0] sel_area;
	logic is_internal;
	logic is_peripheral;
	logic [2:0] target;
	logic undefined_hit;
	logic misaligned_hit;
	logic take_abort;
	logic start_access;
	logic [2:0] owner_onehot;
	logic [2:0] winner_onehot;
	logic [2:0] unread_source;
	logic [2:0] saved_next;
	// Register bus handshake state.
	logic aw_held_reg;
	logic w_held_reg;
	logic [31:0] aw_addr_reg;
	logic [31:0] w_data_reg;
	logic [3:0] w_strb_reg;
	logic do_write;
	logic do_read;
	logic write_remap;
	logic read_status;
	logic [3:0] waddr_low;
	logic [3:0] raddr_low;
	logic [31:0] attribute_word;
	logic [31:0] read_word;
	logic read_mapped;
	logic write_mapped;

	// Fixed priority, lowest index wins.
	assign any_req = |master_req;
	assign winner = master_req[bus_controller_pkg::master_ethernet] ? 2'(bus_controller_pkg::master_ethernet) :
		master_req[bus_controller_pkg::master_dma] ? 2'(bus_controller_pkg::master_dma) :
		2'(bus_controller_pkg::master_cpu);

	assign sel_addr = master_addr[winner];
	assign sel_size = master_size[winner];
	assign sel_type = master_type[winner];
	assign sel_wdata = master_wdata[winner];
	assign sel_region = sel_addr[bus_controller_pkg::region_msb:bus_controller_pkg::region_lsb];
	assign sel_area = sel_addr[bus_controller_pkg::area_msb:bus_controller_pkg::area_lsb];
	assign is_internal = sel_region == bus_controller_pkg::region_internal;
	assign is_peripheral = sel_region == bus_controller_pkg::region_peripheral;

	// Area 0 follows the remap state while each memory keeps its own window too.
	always_comb begin
		target = bus_controller_pkg::target_none;
		if (is_peripheral) begin
			target = bus_controller_pkg::target_peripheral;
		end else if (is_internal) begin
			case (sel_area)
				bus_controller_pkg::area_zero: target = remap_reg ? bus_controller_pkg::target_sram :
					bus_controller_pkg::target_flash;
				bus_controller_pkg::area_flash: target = bus_controller_pkg::target_flash;
				bus_controller_pkg::area_sram: target = bus_controller_pkg::target_sram;
				bus_controller_pkg::area_rom: target = bus_controller_pkg::target_rom;
				default: target = bus_controller_pkg::target_none;
			endcase
		end
	end
	assign undefined_hit = target == bus_controller_pkg::target_none;

	// Fetches from the CPU are never checked; all other accesses are.
	assign misaligned_hit = !(winner == 2'(bus_controller_pkg::master_cpu) &&
		sel_type == bus_controller_pkg::type_fetch) &&
		((sel_size == bus_controller_pkg::size_word && sel_addr[1:0] != 2'h0) ||
		(sel_size == bus_controller_pkg::size_half && sel_addr[0] != 1'b0));

	assign start_access = state_reg == bus_controller_pkg::arb_idle && any_req;
	assign take_abort = start_access && (undefined_hit || misaligned_hit);
	assign owner_onehot = 3'h1 << owner_reg;

	// An abort already shown by a status read must not turn into a saved flag later.
	assign winner_onehot = 3'h1 << winner;
	assign unread_source = source_unread_reg ? last_source_reg : 3'h0;
	assign saved_next = (read_status ? 3'h0 : (saved_reg | unread_source)) & ~winner_onehot;

	always_comb begin
		state_next = state_reg;
		grant_next = 3'h0;
		case (state_reg)
			bus_controller_pkg::arb_idle: begin
				if (start_access && !take_abort) begin
					state_next = bus_controller_pkg::arb_busy;
				end
			end
			bus_controller_pkg::arb_busy: begin
				// The grant is held until the memory answers.
				if (mem_ready) begin
					state_next = bus_controller_pkg::arb_idle;
				end
			end
			default: state_next = bus_controller_pkg::arb_idle;
		endcase
		if (start_access) begin
			grant_next = 3'h1 << winner;
		end else if (state_reg == bus_controller_pkg::arb_busy && !mem_ready) begin
			grant_next = owner_onehot;
		end
	end

	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			state_reg <= bus_controller_pkg::arb_idle;
			owner_reg <= 2'h0;
			master_grant <= 3'h0;
		end else begin
			state_reg <= state_next;
			master_grant <= grant_next;
			if (start_access) begin
				owner_reg <= winner;
			end
		end
	end

	// Memory strobe and master answers.
	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			mem_valid <= 1'b0;
			mem_target <= bus_controller_pkg::target_none;
			mem_addr <= 32'h0;
			mem_size <= bus_controller_pkg::size_byte;
			mem_write <= 1'b0;
			mem_wdata <= 32'h0;
			master_done <= 1'b0;
			master_abort <= 1'b0;
			master_rdata <= 32'h0;
		end else begin
			master_done <= take_abort || (state_reg == bus_controller_pkg::arb_busy && mem_ready);
			// One indication shared by all masters; only the CPU acts on it.
			master_abort <= take_abort;
			if (start_access && !take_abort) begin
				mem_valid <= 1'b1;
				mem_target <= target;
				mem_addr <= sel_addr;
				mem_size <= sel_size;
				mem_write <= sel_type == bus_controller_pkg::type_write;
				mem_wdata <= sel_wdata;
			end else if (mem_ready) begin
				mem_valid <= 1'b0;
			end
			// Data pass byte for byte; every lane keeps its little-endian position.
			if (state_reg == bus_controller_pkg::arb_busy && mem_ready) begin
				master_rdata <= mem_rdata;
			end
		end
	end

	// Abort capture: the newest abort replaces everything but the saved flags.
	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			abort_address_reg <= 32'h0;
			abort_size_field <= bus_controller_pkg::size_byte;
			abort_type_field <= bus_controller_pkg::type_read;
			undefined_address_flag <= 1'b0;
			misaligned_address_flag <= 1'b0;
			last_source_reg <= 3'h0;
		end else if (take_abort) begin
			abort_address_reg <= sel_addr;
			abort_size_field <= sel_size;
			abort_type_field <= sel_type;
			undefined_address_flag <= undefined_hit;
			misaligned_address_flag <= !undefined_hit;
			last_source_reg <= winner_onehot;
		end
	end

	// A master's earlier abort is saved when a newer abort moves the last source away,
	// but only while no status read has shown that earlier abort yet.
	// A new abort in the read cycle does not stop the clear; no flag is saved then.
	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			saved_reg <= 3'h0;
		end else if (take_abort) begin
			saved_reg <= saved_next;
		end else if (read_status) begin
			saved_reg <= 3'h0;
		end
	end

	// The last source counts as unread from its abort until the next status read.
	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			source_unread_reg <= 1'b0;
		end else if (take_abort) begin
			source_unread_reg <= 1'b1;
		end else if (read_status) begin
			source_unread_reg <= 1'b0;
		end
	end

	// Remap toggle.
	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			remap_reg <= 1'b0;
			remap_active <= 1'b0;
		end else begin
			if (write_remap && w_strb_reg[0] && w_data_reg[bus_controller_pkg::remap_toggle_bit]) begin
				remap_reg <= !remap_reg;
			end
			remap_active <= remap_reg;
		end
	end

	// AXI4-Lite slave: address and data are caught in either order.
	// Ready is offered every other cycle, so each take is followed by a refused cycle;
	// this keeps the slave small, and status traffic is far too rare for the lost rate to matter.
	assign do_write = aw_held_reg && w_held_reg && !s_axi_bvalid;
	assign waddr_low = aw_addr_reg[3:0];
	assign write_mapped = aw_addr_reg[31:4] == 28'h0 && waddr_low == bus_controller_pkg::remap_command_offset;
	assign write_remap = do_write && write_mapped;
	assign do_read = s_axi_arvalid && s_axi_arready;
	assign raddr_low = s_axi_araddr[3:0];
	assign read_mapped = s_axi_araddr[31:4] == 28'h0 &&
		(raddr_low == bus_controller_pkg::abort_attribute_offset ||
		raddr_low == bus_controller_pkg::abort_address_offset);
	assign read_status = do_read && s_axi_araddr[31:4] == 28'h0 &&
		raddr_low == bus_controller_pkg::abort_attribute_offset;
	assign attribute_word = (32'(saved_reg) << bus_controller_pkg::saved_lsb) |
		(32'(last_source_reg) << bus_controller_pkg::last_source_lsb) |
		(32'(abort_type_field) << bus_controller_pkg::type_lsb) |
		(32'(abort_size_field) << bus_controller_pkg::size_lsb) |
		(32'(misaligned_address_flag) << bus_controller_pkg::misaligned_bit) |
		(32'(undefined_address_flag) << bus_controller_pkg::undefined_bit);
	assign read_word = !read_mapped ? 32'h0 :
		raddr_low == bus_controller_pkg::abort_attribute_offset ? attribute_word : abort_address_reg;

	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			aw_held_reg <= 1'b0;
			w_held_reg <= 1'b0;
			aw_addr_reg <= 32'h0;
			w_data_reg <= 32'h0;
			w_strb_reg <= 4'h0;
			s_axi_awready <= 1'b0;
			s_axi_wready <= 1'b0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= bus_controller_pkg::axi_okay;
		end else begin
			s_axi_awready <= !aw_held_reg && !s_axi_awready && !s_axi_bvalid;
			s_axi_wready <= !w_held_reg && !s_axi_wready && !s_axi_bvalid;
			if (s_axi_awvalid && s_axi_awready) begin
				aw_held_reg <= 1'b1;
				aw_addr_reg <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_held_reg <= 1'b1;
				w_data_reg <= s_axi_wdata;
				w_strb_reg <= s_axi_wstrb;
			end
			if (do_write) begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= write_mapped ? bus_controller_pkg::axi_okay : bus_controller_pkg::axi_slverr;
				aw_held_reg <= 1'b0;
				w_held_reg <= 1'b0;
			end else if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0;
			s_axi_rresp <= bus_controller_pkg::axi_okay;
		end else begin
			s_axi_arready <= !s_axi_arready && !s_axi_rvalid;
			if (do_read) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rdata <= read_word;
				s_axi_rresp <= read_mapped ? bus_controller_pkg::axi_okay : bus_controller_pkg::axi_slverr;
			end else if (s_axi_rvalid && s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end
endmodule : system_bus_controller

//--- testbench/bus_controller_monitor.sv
// Checker of the system bus controller port behaviour.
module bus_monitor (
	// Clock and reset
	input wire logic core_clk,
	input wire logic reset,
	// Master side
	input wire logic [2:0] master_req,
	input wire logic [31:0] master_addr [3],
	input wire logic [1:0] master_size [3],
	input wire logic [1:0] master_type [3],
	input wire logic [2:0] master_grant,
	input wire logic master_done,
	input wire logic master_abort,
	// Memory and register side
	input wire logic mem_valid,
	input wire logic mem_ready,
	input wire logic [2:0] mem_target,
	input wire logic [31:0] mem_addr,
	input wire logic remap_active,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic s_axi_rvalid
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [1:0] gi;
	logic [31:0] ga;
	logic g_und;
	logic g_mis;
	// The granted master still holds its address, size and type, so they explain the outcome.
	assign gi = master_grant[0] ? 2'h0 : master_grant[1] ? 2'h1 : 2'h2;
	assign ga = master_addr[gi];
	assign g_und = !(ga[31:28] inside {4'h0, 4'hf}) || (ga[31:28] == 4'h0 && ga[27:20] > 8'h03);
	assign g_mis = !(gi == 2'h2 && master_type[2] == bus_controller_pkg::type_fetch)
		&& (master_size[gi] == 2'h2 ? ga[1:0] != 2'h0 : master_size[gi] == 2'h1 && ga[0]);
	default clocking @(posedge core_clk); endclocking
	default disable iff (reset);
	a_fixed_priority: assert property ($changed(master_grant) && |master_grant
		|-> ($past(master_req) & (master_grant - 3'h1)) == 3'h0) else $error("lower master granted");
	a_grant_held: assert property (|master_grant && !master_done && !mem_ready |=> $stable(master_grant))
		else $error("grant moved mid transfer");
	a_undefined_abort: assert property (|master_grant && g_und |-> master_abort && master_done)
		else $error("undefined address not aborted");
	a_misaligned_abort: assert property (|master_grant && g_mis |-> master_abort)
		else $error("misaligned access not aborted");
	a_clean_no_abort: assert property (|master_grant && !g_und && !g_mis |-> !master_abort)
		else $error("legal access aborted");
	a_abort_no_access: assert property (master_abort |-> master_done && !mem_valid)
		else $error("aborted access reached memory");
	a_ready_ends: assert property (mem_valid && mem_ready |=> master_done && !master_abort && !mem_valid)
		else $error("transfer did not end on ready");
	a_mem_hold: assert property (mem_valid && !mem_ready |=> mem_valid && $stable(mem_addr))
		else $error("memory request dropped");
	a_remap_target: assert property ($rose(mem_valid) && ga[31:20] == 12'h000
		|-> mem_target == (remap_active ? 3'h2 : 3'h1)) else $error("area zero wrong memory");
	a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid) else $error("no read answer");
	cover property (master_abort && master_grant[2]);
	cover property (mem_valid && mem_ready);
	cover property (master_grant[1] && master_req[2]);
endmodule : bus_monitor

bind system_bus_controller bus_monitor i_monitor (.core_clk(core_clk), .reset(reset), .master_req(master_req),
	.master_addr(master_addr), .master_size(master_size), .master_type(master_type), .master_grant(master_grant),
	.master_done(master_done), .master_abort(master_abort), .mem_valid(mem_valid), .mem_ready(mem_ready),
	.mem_target(mem_target), .mem_addr(mem_addr), .remap_active(remap_active), .s_axi_arvalid(s_axi_arvalid),
	.s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid));

//--- testbench/mem_model.sv
// Behavioural memory answering the controller after a chosen delay.
module mem_model (
	// Clock and reset
	input wire logic core_clk,
	input wire logic reset,
	// Memory request and answer
	input wire logic mem_valid,
	input wire logic [31:0] mem_addr,
	input wire logic [1:0] delay,
	output logic mem_ready,
	output logic [31:0] mem_rdata
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [1:0] count_reg;
	// Between answers the data toggles, so a stale word is never taken for a fresh one.
	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			mem_ready <= 1'b0;
			count_reg <= 2'h0;
			mem_rdata <= 32'h0;
		end else if (mem_ready) begin
			mem_ready <= 1'b0;
			count_reg <= 2'h0;
			mem_rdata <= ~mem_rdata;
		end else if (mem_valid && count_reg == delay) begin
			mem_ready <= 1'b1;
			mem_rdata <= {8'ha5, 10'h000, mem_addr[13:0]};
		end else begin
			count_reg <= count_reg + {1'b0, mem_valid};
			mem_rdata <= ~mem_rdata;
		end
	end
endmodule : mem_model

//--- testbench/system_bus_controller_test.sv
// Self-checking bench of the system bus controller.
module system_bus_controller_test;
	timeunit 1ns;
	timeprecision 1ns;
	logic core_clk = 1'b0;
	logic reset = 1'b1;
	logic [2:0] master_req = 3'h0;
	logic [31:0] master_addr [3] = '{default: 32'h0};
	logic [1:0] master_size [3] = '{default: 2'h0};
	logic [1:0] master_type [3] = '{default: 2'h0};
	logic [31:0] master_wdata [3] = '{default: 32'h0};
	logic [31:0] s_axi_awaddr = 32'h0, s_axi_wdata = 32'h0, s_axi_araddr = 32'h0;
	logic [3:0] s_axi_wstrb = 4'hf;
	logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
	logic [2:0] master_grant, mem_target, tgt;
	logic master_done, master_abort, mem_valid, mem_write, mem_ready, remap_active, remap = 1'b0;
	logic [31:0] master_rdata, mem_addr, mem_wdata, mem_rdata, s_axi_rdata, rd, lf = 32'h51;
	logic [1:0] mem_size, s_axi_bresp, s_axi_rresp, rs, delay = 2'h0;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	int n_mismatch = 0;
	int checks = 0;
	system_bus_controller i_dut (.*);
	mem_model i_mem (.*);
	initial forever #50 core_clk = ~core_clk;
	function automatic logic [31:0] lfsr_step(input logic [31:0] x);
		return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
	endfunction : lfsr_step
	// Returns the misaligned and undefined flags; fetches of the cpu are never misaligned.
	function automatic logic [1:0] cls(input int m, input logic [31:0] a, input logic [1:0] s, t);
		logic u;
		u = !(a[31:28] inside {4'h0, 4'hf}) || (a[31:28] == 4'h0 && a[27:20] > 8'h03);
		return {!u && !(m == 2 && t == 2'h2) && (s == 2'h2 ? a[1:0] != 2'h0 : s == 2'h1 && a[0]), u};
	endfunction : cls
	function automatic logic [2:0] exp_tgt(input logic [31:0] a);
		if (a[31:28] == 4'hf) return 3'h4;
		case (a[21:20])
			2'h0: return remap ? 3'h2 : 3'h1;
			2'h1: return 3'h1;
			2'h2: return 3'h2;
			default: return 3'h3;
		endcase
	endfunction : exp_tgt
	task automatic chk(input logic [31:0] got, exp, input string what);
		checks++;
		if (got !== exp) begin
			n_mismatch++;
			$display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
		end
	endtask : chk
	task automatic axi_wr(input logic [31:0] a, d);
		int n = 0;
		@(posedge core_clk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do begin
			@(posedge core_clk);
			n++;
			if (s_axi_awready && s_axi_awvalid) s_axi_awvalid <= 1'b0;
			if (s_axi_wready && s_axi_wvalid) s_axi_wvalid <= 1'b0;
		end while (!s_axi_bvalid && n < 20);
		if (!s_axi_bvalid) chk(0, 1, "write answer");
		rs = s_axi_bresp;
		s_axi_bready <= 1'b0;
	endtask : axi_wr
	task automatic axi_rd(input logic [31:0] a);
		int n = 0;
		@(posedge core_clk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do begin
			@(posedge core_clk);
			n++;
			if (s_axi_arready && s_axi_arvalid) s_axi_arvalid <= 1'b0;
		end while (!s_axi_rvalid && n < 20);
		if (!s_axi_rvalid) chk(0, 1, "read answer");
		rd = s_axi_rdata;
		rs = s_axi_rresp;
		s_axi_rready <= 1'b0;
	endtask : axi_rd
	// The request is dropped at the edge that ends the transfer, or it would be taken again.
	task automatic access(input int m, input logic [31:0] a, input logic [1:0] s, t);
		logic [1:0] c;
		int n = 0;
		c = cls(m, a, s, t);
		@(posedge core_clk);
		master_addr[m] <= a;
		master_size[m] <= s;
		master_type[m] <= t;
		master_wdata[m] <= lf;
		master_req[m] <= 1'b1;
		@(posedge core_clk);
		if (c == 2'h0) do begin
			@(posedge core_clk);
			n++;
			tgt = mem_target;
		end while (!(mem_valid && mem_ready) && n < 20);
		if (c == 2'h0) begin
			chk({mem_write, mem_size}, {t == 2'h1, s}, "memory request");
			chk(mem_wdata, lf, "write data");
		end
		master_req[m] <= 1'b0;
		@(posedge core_clk);
		chk(master_done, 1, "done");
		chk(master_abort, |c, "abort");
		if (c == 2'h0) begin
			chk(tgt, exp_tgt(a), "target");
			if (t != 2'h1) chk(master_rdata, {8'ha5, 10'h000, a[13:0]}, "read data");
		end else begin
			axi_rd(32'h8);
			chk(rd, a, "abort address");
			axi_rd(32'h4);
			chk(rd, {13'h0, 3'h1 << m, 4'h0, t, s, 6'h0, c}, "attributes");
		end
	endtask : access
	task automatic give_verdict;
		$display("checks %0d n_mismatch %0d", checks, n_mismatch);
		if (n_mismatch == 0 && checks > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask : give_verdict
	initial begin
		repeat (5000) @(posedge core_clk);
		n_mismatch++;
		give_verdict;
	end
	initial begin
		repeat (4) @(posedge core_clk);
		reset <= 1'b0;
		axi_rd(32'h4);
		chk(rd, 32'h0, "attribute reset");
		axi_rd(32'h8);
		chk(rd, 32'h0, "address reset");
		$display("test reset done");
		// All three masters request at once and abort in priority order; each drops its request after its turn.
		@(posedge core_clk);
		for (int i = 0; i < 3; i++) begin
			master_addr[i] <= 32'h10000010 << i;
			master_size[i] <= 2'h2;
			master_type[i] <= 2'h0;
		end
		master_req <= 3'h7;
		for (int i = 0; i < 3; i++) begin
			@(posedge core_clk);
			master_req[i] <= 1'b0;
		end
		axi_rd(32'h8);
		chk(rd, 32'h40000040, "last abort address");
		axi_rd(32'h4);
		chk(rd, 32'h03040201, "attributes with saved");
		axi_rd(32'h4);
		chk(rd, 32'h00040201, "saved cleared");
		$display("test priority done");
		for (int k = 0; k < 4; k++) begin
			axi_wr(32'h0, {31'h0, k != 0});
			chk(rs, 2'h0, "remap response");
			remap = remap ^ (k != 0);
			access(2, 32'h00000100 + 4 * k, 2'h2, 2'h2);
			chk(remap_active, remap, "remap state");
			access(1, 32'h00200102, 2'h1, 2'h1);
			access(0, 32'h00100101, 2'h0, 2'h0);
		end
		axi_rd(32'hc);
		chk({rd, rs}, {32'h0, 2'h2}, "unmapped read");
		axi_wr(32'h10, 32'h1);
		chk(rs, 2'h2, "unmapped write");
		$display("test remap done");
		for (int k = 0; k < 60; k++) begin
			lf = lfsr_step(lf);
			delay <= lf[11:10];
			access(lf[13:12] % 3, {lf[2] ? 4'h0 : lf[3] ? 4'hf : lf[31:28], lf[4] ? lf[27:20] : {6'h0, lf[21:20]},
				lf[19:0]}, lf[6:5] == 2'h3 ? 2'h2 : lf[6:5], lf[13:12] % 3 == 2 && lf[7] ? 2'h2 : {1'b0, lf[8]});
		end
		$display("test random done");
		give_verdict;
	end
endmodule : system_bus_controller_test
